// *** hw/bcpc_top.sv ***
// Break condition unit with four-channel performance counter
`timescale 1ns/100ps
`include "bcpc_params.svh"

module bcpc_top #(
    parameter int NUM_CH = 4,
    parameter int CNT_W = 32,
    parameter int BCNT_W = 16,
    parameter bit HAS_DSP = 1'b1,
    parameter bit HAS_MMU = 1'b1,
    parameter bit HAS_XYRAM = 1'b1,
    parameter bit HAS_URAM = 1'b1
) (
    // Clock, reset, clock enable
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`BCPC_ADDR_W-1:0] reg_addr_i,
    input wire logic [`BCPC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`BCPC_DATA_W-1:0] reg_rdata_o,
    // CPU execution status
    input wire logic run_start_i,
    input wire logic retire_i,
    input wire logic delay_slot_i,
    input wire logic multistep_i,
    input wire logic sw_bp_exec_i,
    input wire logic brk1_match_i,
    input wire logic brk2_match_i,
    input wire logic [`BCPC_EV_W-1:0] ev_i,
    // Debug outputs
    output logic halt_req_o,
    output logic window_open_o,
    output logic [NUM_CH-1:0] ovf_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must be 1 to 4");
    end
    if (CNT_W < 2 || CNT_W > `BCPC_DATA_W) begin : g_bad_cnt
        $error("CNT_W must be 2 to 32");
    end
    if (BCNT_W < 1 || BCNT_W > `BCPC_DATA_W) begin : g_bad_bcnt
        $error("BCNT_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    bcpc_pkg::bcpc_mode_t mode;
    logic [1:0] brk_en;
    logic [BCNT_W-1:0] brk_lim [2];
    logic [BCNT_W-1:0] brk_run [2];
    logic [BCNT_W-1:0] next_run [2];
    bcpc_pkg::bcpc_ev_t ch_sel [NUM_CH];
    logic [CNT_W-1:0] ch_cnt [NUM_CH];
    logic [NUM_CH-1:0] ch_ovf;
    logic [1:0] raw;
    logic [1:0] hit;
    logic wr_ctrl;
    logic init_pulse;
    logic win_q;
    logic pend_q;
    logic [`BCPC_SLIP_W-1:0] slip_q;
    logic halt_q;
    logic brk_stop;
    logic halt_set;
    logic win_open;
    logic win_close;
    logic [`BCPC_EV_W-1:0] ev_eff;
    logic [`BCPC_DATA_W-1:0] rd_mux;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == `BCPC_OFF_CTRL);
    assign init_pulse = wr_ctrl && reg_wdata_i[`BCPC_CTRL_INIT];

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Mode and break enables
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode <= bcpc_pkg::mode_normal;
            brk_en <= `BCPC_RST_EN;
        end else if (ce_i && wr_ctrl) begin
            mode <= bcpc_pkg::bcpc_mode_t'(reg_wdata_i[`BCPC_CTRL_MODE_LSB
                    +: `BCPC_CTRL_MODE_W]);
            brk_en[0] <= reg_wdata_i[`BCPC_CTRL_BRK1_EN];
            brk_en[1] <= reg_wdata_i[`BCPC_CTRL_BRK2_EN];
        end
    end

    // Execution count limits; zero means a plain break
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            brk_lim[0] <= '0;
            brk_lim[1] <= '0;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == `BCPC_OFF_BCNT1) begin
                brk_lim[0] <= reg_wdata_i[BCNT_W-1:0];
            end
            if (reg_addr_i == `BCPC_OFF_BCNT2) begin
                brk_lim[1] <= reg_wdata_i[BCNT_W-1:0];
            end
        end
    end

    // Channel selectors; undefined codes fall back to disabled
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (srst_i) begin
                ch_sel[i] <= bcpc_pkg::ev_off;
            end else if (ce_i && reg_wr_i && reg_addr_i ==
                         `BCPC_ADDR_W'(`BCPC_OFF_SEL0
                         + i * `BCPC_REG_STRIDE)) begin
                if (reg_wdata_i[`BCPC_SEL_W-1:0] >
                    bcpc_pkg::ev_cacheable_area) begin
                    ch_sel[i] <= bcpc_pkg::ev_off;
                end else begin
                    ch_sel[i] <= bcpc_pkg::bcpc_ev_t'(
                        reg_wdata_i[`BCPC_SEL_W-1:0]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break condition matching

    // Raw matches and execution-count qualification
    always_comb begin
        raw[0] = brk1_match_i && brk_en[0];
        raw[1] = brk2_match_i && brk_en[1] && !sw_bp_exec_i;
        for (int k = 0; k < 2; k++) begin
            next_run[k] = brk_run[k] + BCNT_W'(1);
            if (brk_lim[k] == '0) begin
                hit[k] = raw[k];
            end else begin
                hit[k] = raw[k] && !multistep_i
                         && (next_run[k] == brk_lim[k]);
            end
        end
    end

    // Match counters, rearmed on each run and each qualified fire
    always_ff @(posedge clk_sys_i) begin
        for (int k = 0; k < 2; k++) begin
            if (srst_i) begin
                brk_run[k] <= '0;
            end else if (ce_i) begin
                if (run_start_i) begin
                    brk_run[k] <= '0;
                end else if (raw[k] && !multistep_i && brk_lim[k] != '0) begin
                    brk_run[k] <= hit[k] ? '0 : next_run[k];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Halt request

    assign brk_stop = (mode == bcpc_pkg::mode_normal) && (hit != 2'h0);
    assign halt_set = pend_q && !halt_q
                      && (slip_q == `BCPC_SLIP_W'(`BCPC_HALT_SLIP));

    // Pending break and retirement slip
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pend_q <= 1'b0;
            slip_q <= '0;
        end else if (ce_i) begin
            if (run_start_i) begin
                pend_q <= 1'b0;
                slip_q <= '0;
            end else if (brk_stop && !pend_q) begin
                pend_q <= 1'b1;
                slip_q <= '0;
            end else if (pend_q && retire_i && !delay_slot_i
                         && slip_q != `BCPC_SLIP_W'(`BCPC_HALT_SLIP)) begin
                slip_q <= slip_q + `BCPC_SLIP_W'(1);
            end
        end
    end

    // Halt held until the next run
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            halt_q <= 1'b0;
        end else if (ce_i) begin
            if (run_start_i) begin
                halt_q <= 1'b0;
            end else if (halt_set) begin
                halt_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement window

    always_comb begin
        unique case (mode)
            bcpc_pkg::mode_normal: begin
                win_open = run_start_i;
                win_close = halt_set;
            end
            bcpc_pkg::mode_c1_to_c2: begin
                win_open = hit[0];
                win_close = hit[1];
            end
            bcpc_pkg::mode_c2_to_c1: begin
                win_open = hit[1];
                win_close = hit[0];
            end
            default: begin
                win_open = 1'b0;
                win_close = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            win_q <= 1'b0;
        end else if (ce_i) begin
            if (win_close) begin
                win_q <= 1'b0;
            end else if (win_open) begin
                win_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter channels

    // Event vector with fixed and absent units masked
    always_comb begin
        ev_eff = ev_i;
        ev_eff[bcpc_pkg::ev_off] = 1'b0;
        ev_eff[bcpc_pkg::ev_elapsed_time] = 1'b1;
        if (!HAS_DSP) begin
            ev_eff[bcpc_pkg::ev_dsp_instr] = 1'b0;
        end
        if (!HAS_MMU) begin
            ev_eff[bcpc_pkg::ev_dtlb_miss] = 1'b0;
            ev_eff[bcpc_pkg::ev_itlb_miss] = 1'b0;
        end
        if (!HAS_XYRAM) begin
            ev_eff[bcpc_pkg::ev_xyram_stall] = 1'b0;
        end
        if (!HAS_URAM) begin
            ev_eff[bcpc_pkg::ev_uram_stall] = 1'b0;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        bcpc_chan_if #(.CNT_W(CNT_W)) cif ();
        assign cif.ce = ce_i;
        assign cif.clr = init_pulse;
        assign cif.win = win_q;
        assign cif.sel = ch_sel[i];
        assign cif.ev = ev_eff;
        assign ch_cnt[i] = cif.cnt;
        assign ch_ovf[i] = cif.ovf;
        bcpc_chan #(.CNT_W(CNT_W)) u_chan (
            .clk_sys_i(clk_sys_i),
            .srst_i(srst_i),
            .bus(cif.chan)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read

    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        if (reg_addr_i == `BCPC_OFF_CTRL) begin
            rd_mux[`BCPC_CTRL_MODE_LSB +: `BCPC_CTRL_MODE_W] = mode;
            rd_mux[`BCPC_CTRL_BRK1_EN] = brk_en[0];
            rd_mux[`BCPC_CTRL_BRK2_EN] = brk_en[1];
        end else if (reg_addr_i == `BCPC_OFF_STAT) begin
            rd_mux[`BCPC_STAT_WIN] = win_q;
            rd_mux[`BCPC_STAT_HALT] = halt_q;
            rd_mux[`BCPC_STAT_PEND] = pend_q;
            rd_mux[`BCPC_STAT_OVF_LSB +: NUM_CH] = ch_ovf;
        end else if (reg_addr_i == `BCPC_OFF_BCNT1) begin
            rd_mux[BCNT_W-1:0] = brk_lim[0];
        end else if (reg_addr_i == `BCPC_OFF_BCNT2) begin
            rd_mux[BCNT_W-1:0] = brk_lim[1];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr_i == `BCPC_ADDR_W'(`BCPC_OFF_SEL0
                + i * `BCPC_REG_STRIDE)) begin
                rd_mux[`BCPC_SEL_W-1:0] = ch_sel[i];
            end
            if (reg_addr_i == `BCPC_ADDR_W'(`BCPC_OFF_CNT0
                + i * `BCPC_REG_STRIDE)) begin
                rd_mux[CNT_W-1:0] = ch_cnt[i];
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign halt_req_o = halt_q;
    assign window_open_o = win_q;
    assign ovf_o = ch_ovf;

endmodule // bcpc_top

// *** hw/bcpc_params.svh ***
// Constants for the break condition and performance counter block
`ifndef BCPC_PARAMS_SVH
`define BCPC_PARAMS_SVH

// Register bus geometry
`define BCPC_ADDR_W 8
`define BCPC_DATA_W 32
`define BCPC_REG_STRIDE 4

// Register byte offsets
`define BCPC_OFF_CTRL 8'h00
`define BCPC_OFF_STAT 8'h04
`define BCPC_OFF_BCNT1 8'h08
`define BCPC_OFF_BCNT2 8'h0C
`define BCPC_OFF_SEL0 8'h10
`define BCPC_OFF_CNT0 8'h20

// Control register fields
`define BCPC_CTRL_MODE_LSB 0
`define BCPC_CTRL_MODE_W 2
`define BCPC_CTRL_BRK1_EN 2
`define BCPC_CTRL_BRK2_EN 3
`define BCPC_CTRL_INIT 4

// Status register fields
`define BCPC_STAT_WIN 0
`define BCPC_STAT_HALT 1
`define BCPC_STAT_PEND 2
`define BCPC_STAT_OVF_LSB 8

// Selector field and event vector
`define BCPC_SEL_W 5
`define BCPC_EV_W 32

// Reset values
`define BCPC_RST_EN 2'h0

// Timing and increments
`define BCPC_HALT_SLIP 2
`define BCPC_SLIP_W 2
`define BCPC_BRANCH_INC 2'h2
`define BCPC_UNIT_INC 2'h1

`endif

// *** hw/bcpc_pkg.sv ***
// Types shared by the break condition and performance counter block
package bcpc_pkg;

    // Measurement window start/stop modes
    typedef enum logic [1:0] {
        mode_normal,
        mode_c1_to_c2,
        mode_c2_to_c1
    } bcpc_mode_t;

    // Channel event selector codes, in selector order
    typedef enum logic [4:0] {
        ev_off,
        ev_elapsed_time,
        ev_exec_states,
        ev_branch,
        ev_instr,
        ev_dsp_instr,
        ev_id_conflict,
        ev_other_conflict,
        ev_exception,
        ev_dtlb_miss,
        ev_itlb_miss,
        ev_interrupt,
        ev_block_bit,
        ev_priv_mode,
        ev_icache_miss,
        ev_dcache_miss,
        ev_fetch_stall,
        ev_data_stall,
        ev_icache_stall,
        ev_dcache_stall,
        ev_cacheable_stall,
        ev_xyram_stall,
        ev_uram_stall,
        ev_mem_access_stall,
        ev_other_access,
        ev_uncached_area,
        ev_uncached_instr,
        ev_uncached_data,
        ev_cacheable_area
    } bcpc_ev_t;

endpackage

// *** hw/bcpc_chan_if.sv ***
// Carrier between the block top and one counter channel
`timescale 1ns/100ps
`include "bcpc_params.svh"

interface bcpc_chan_if #(
    parameter int CNT_W = 32
);
    logic ce;
    logic clr;
    logic win;
    bcpc_pkg::bcpc_ev_t sel;
    logic [`BCPC_EV_W-1:0] ev;
    logic [CNT_W-1:0] cnt;
    logic ovf;

    modport top (output ce, clr, win, sel, ev, input cnt, ovf);
    modport chan (input ce, clr, win, sel, ev, output cnt, ovf);
endinterface

// *** hw/bcpc_chan.sv ***
// One performance counter channel with event select and overflow flag
`timescale 1ns/100ps
`include "bcpc_params.svh"

module bcpc_chan #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Control and result
    bcpc_chan_if.chan bus
);

    logic [CNT_W-1:0] cnt_q;
    logic ovf_q;
    logic hit;
    logic [1:0] inc;
    logic [CNT_W:0] next_sum;

    // Event qualification and increment size
    always_comb begin
        hit = bus.win && (bus.sel != bcpc_pkg::ev_off) && bus.ev[bus.sel];
        inc = 2'h0;
        if (hit) begin
            if (bus.sel == bcpc_pkg::ev_branch) begin
                inc = `BCPC_BRANCH_INC;
            end else begin
                inc = `BCPC_UNIT_INC;
            end
        end
        next_sum = {1'b0, cnt_q} + (CNT_W+1)'(inc);
    end

    // Counter; wraps, the flag tells software the value is bad
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_q <= '0;
        end else if (bus.ce) begin
            if (bus.clr) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= next_sum[CNT_W-1:0];
            end
        end
    end

    // Sticky overflow; a carry in the clearing cycle still lands
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ovf_q <= 1'b0;
        end else if (bus.ce) begin
            if (next_sum[CNT_W]) begin
                ovf_q <= 1'b1;
            end else if (bus.clr) begin
                ovf_q <= 1'b0;
            end
        end
    end

    assign bus.cnt = cnt_q;
    assign bus.ovf = ovf_q;

endmodule // bcpc_chan

// *** tb/bcpc_props.sv ***
// Assertion checker for the break and performance counter block
`timescale 1ns/100ps
`include "bcpc_params.svh"

module bcpc_props #(
    parameter int NUM_CH = 4
) (
    // Clock, reset, clock enable
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`BCPC_ADDR_W-1:0] reg_addr_i,
    input wire logic [`BCPC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`BCPC_DATA_W-1:0] reg_rdata_o,
    // Execution status
    input wire logic run_start_i,
    input wire logic retire_i,
    input wire logic delay_slot_i,
    input wire logic brk1_match_i,
    input wire logic brk2_match_i,
    // Debug outputs
    input wire logic halt_req_o,
    input wire logic window_open_o,
    input wire logic [NUM_CH-1:0] ovf_o
);
    logic [1:0] mode_q;
    logic ctrl_wr;
    logic opn;
    logic cls;
    logic [1:0] ret_hist;

    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    // Causes that may open or close the window in the current mode
    assign ctrl_wr = ce_i && reg_wr_i && reg_addr_i == `BCPC_OFF_CTRL;
    assign opn = mode_q == 2'h0 ? run_start_i
               : mode_q == 2'h1 ? brk1_match_i : brk2_match_i;
    // Normal mode closes on the halt edge itself, judged in the property
    assign cls = mode_q == 2'h1 ? brk2_match_i
               : mode_q == 2'h2 ? brk1_match_i : mode_q == 2'h3;

    // Mode shadow, so window rules can be judged from the ports alone
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode_q <= 2'h0;
        end else if (ctrl_wr) begin
            mode_q <= reg_wdata_i[1:0];
        end
    end

    // Non-slot retires of the last two enabled cycles
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ret_hist <= 2'h0;
        end else if (ce_i) begin
            ret_hist <= {ret_hist[0], retire_i && !delay_slot_i};
        end
    end

    sequence s_stat_rd;
        ce_i && reg_rd_i && reg_addr_i == `BCPC_OFF_STAT;
    endsequence
    sequence s_opens;
        !window_open_o ##1 window_open_o;
    endsequence
    sequence s_closes;
        window_open_o ##1 !window_open_o;
    endsequence

    AST_RD_IDLE: assert property (
        ce_i && !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data not zero when idle");
    AST_STAT_MIRROR: assert property (
        s_stat_rd |=> reg_rdata_o[0] == $past(window_open_o)
            && reg_rdata_o[1] == $past(halt_req_o)
            && reg_rdata_o[8 +: NUM_CH] == $past(ovf_o))
        else $error("status read disagrees with outputs");
    AST_OVF_STICKY: assert property (
        !(ctrl_wr && reg_wdata_i[4]) |=>
            (ovf_o & $past(ovf_o)) == $past(ovf_o))
        else $error("overflow flag dropped without init");
    AST_HALT_AFTER_RETIRE: assert property (
        $rose(halt_req_o) |-> $past(ce_i) && ret_hist[1])
        else $error("halt not tied to a non-slot retire");
    AST_HALT_HOLDS: assert property (
        halt_req_o && !run_start_i |=> halt_req_o)
        else $error("halt dropped before run start");
    AST_NO_HALT_WINMODE: assert property (
        mode_q != 2'h0 |=> !$rose(halt_req_o))
        else $error("halt raised in a window mode");
    AST_CE_FREEZE: assert property (
        !ce_i |=> $stable(window_open_o) && $stable(halt_req_o)
            && $stable(ovf_o))
        else $error("state moved with clock enable low");
    AST_WIN_OPEN: assert property (
        s_opens |-> $past(opn && ce_i))
        else $error("window opened without its start event");
    AST_WIN_CLOSE: assert property (
        s_closes |-> $past(ce_i) && ($past(cls) || $rose(halt_req_o)))
        else $error("window closed without its end event");
    AST_RUN_OPENS: assert property (
        ce_i && run_start_i && mode_q == 2'h0 |=> window_open_o)
        else $error("run start did not open the window");
endmodule // bcpc_props

////////////////////////////////////////////////////////////////////////
bind bcpc_top bcpc_props #(.NUM_CH(NUM_CH)) u_props (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .run_start_i(run_start_i), .retire_i(retire_i),
    .delay_slot_i(delay_slot_i), .brk1_match_i(brk1_match_i),
    .brk2_match_i(brk2_match_i), .halt_req_o(halt_req_o),
    .window_open_o(window_open_o), .ovf_o(ovf_o)
);

// *** tb/bcpc_emu.sv ***
// Debug emulator model: host side of the register port
`timescale 1ns/100ps
`include "bcpc_params.svh"

module bcpc_emu (
    // Clock
    input wire logic clk_sys_i,
    // Register port
    output logic [`BCPC_ADDR_W-1:0] reg_addr_o,
    output logic [`BCPC_DATA_W-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [`BCPC_DATA_W-1:0] reg_rdata_i
);
    // Idle bus from time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 32'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // One-cycle write; the slave never stalls
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
    endtask

    // Read data is taken mid-cycle, the only cycle it stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rdata_i;
    endtask

    task automatic arm(input logic [1:0] m);
        wr(`BCPC_OFF_CTRL, 32'h0000001C | {30'h0, m});
    endtask
endmodule // bcpc_emu

// *** tb/tb.sv ***
// Self-checking bench for the break and performance counter block
`timescale 1ns/100ps
`include "bcpc_params.svh"

module tb;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, d;
    logic reg_wr_i, reg_rd_i, halt_req_o, window_open_o;
    logic run_start_i = 1'b0, retire_i = 1'b0, delay_slot_i = 1'b0;
    logic multistep_i = 1'b0, sw_bp_exec_i = 1'b0;
    logic brk1_match_i = 1'b0, brk2_match_i = 1'b0;
    logic [31:0] ev_i = 32'h0;
    logic [3:0] ovf_o, ovf_nw, ovf_x;
    int error_cnt = 0, n_checks = 0, cyc = 0;

    bcpc_top dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .run_start_i(run_start_i), .retire_i(retire_i),
        .delay_slot_i(delay_slot_i), .multistep_i(multistep_i),
        .sw_bp_exec_i(sw_bp_exec_i), .brk1_match_i(brk1_match_i),
        .brk2_match_i(brk2_match_i), .ev_i(ev_i), .halt_req_o(halt_req_o),
        .window_open_o(window_open_o), .ovf_o(ovf_o)
    );
    bcpc_emu emu (
        .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o)
    );
    // Narrow twin on the same stimulus, so overflow is reachable
    bcpc_top #(.CNT_W(4)) dut_ovf (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(),
        .run_start_i(run_start_i), .retire_i(retire_i),
        .delay_slot_i(delay_slot_i), .multistep_i(multistep_i),
        .sw_bp_exec_i(sw_bp_exec_i), .brk1_match_i(brk1_match_i),
        .brk2_match_i(brk2_match_i), .ev_i(ev_i), .halt_req_o(),
        .window_open_o(), .ovf_o(ovf_nw)
    );

    // 50 MHz clock and a hang guard well above the planned run
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One-cycle pulse on {retire, run start, cond 2, cond 1}
    task automatic step(input logic [3:0] w);
        @(posedge clk_sys_i);
        {retire_i, run_start_i, brk2_match_i, brk1_match_i} <= w;
        @(posedge clk_sys_i);
        {retire_i, run_start_i, brk2_match_i, brk1_match_i} <= 4'h0;
    endtask

    // Output looked at mid-cycle, then back onto a rising edge
    task automatic see(input string nm, input logic e);
        @(negedge clk_sys_i);
        if (nm == "halt") begin
            chk(nm, {31'h0, e}, {31'h0, halt_req_o});
        end else begin
            chk(nm, {31'h0, e}, {31'h0, window_open_o});
        end
        @(posedge clk_sys_i);
    endtask

    // Window of 31 cycles; event bit k, up to 28, is high for k of them
    function automatic logic [31:0] want(input int k);
        if (k == 1) return 32'h1F;
        if (k == 3) return 32'h6;
        if (k == 0 || k > 28) return 32'h0;
        return 32'(k);
    endfunction

    initial begin
        repeat (8) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        // reset values, unmapped holes read zero
        for (int a = 0; a < 64; a += 4) begin
            emu.rd(8'(a), d);
            chk("reset", 32'h0, d);
        end
        for (int b = 0; b < 8; b++) begin
            for (int i = 0; i < 4; i++) begin
                emu.wr(8'h10 + 8'(4 * i), 32'(4 * b + i));
            end
            emu.arm(2'(1 + b % 2));
            step(b % 2 == 0 ? 4'h1 : 4'h2);
            for (int j = 0; j < 29; j++) begin
                ev_i <= ~((32'h2 << j) - 32'h1);
                @(posedge clk_sys_i);
            end
            ev_i <= 32'h0;
            step(b % 2 == 0 ? 4'h2 : 4'h1);
            emu.rd(`BCPC_OFF_STAT, d);
            chk("stat", 32'h0, d & 32'h3);
            for (int i = 0; i < 4; i++) begin
                emu.rd(8'h10 + 8'(4 * i), d);
                chk("sel", 4 * b + i > 28 ? 32'h0 : 32'(4 * b + i),
                    d);
                emu.rd(8'h20 + 8'(4 * i), d);
                chk("count", want(4 * b + i), d);
            end
            // Four-bit twin wraps above 15; init clears it each round
            for (int i = 0; i < 4; i++) begin
                ovf_x[i] = want(4 * b + i) > 32'hF;
            end
            chk("ovf narrow", 32'(ovf_x), 32'(ovf_nw));
            chk("ovf", 32'h0, 32'(ovf_o));
        end
        // masked, counted multi-step, frozen matches never close
        emu.arm(2'h1);
        step(4'h1);
        sw_bp_exec_i <= 1'b1;
        step(4'h2);
        sw_bp_exec_i <= 1'b0;
        see("window", 1'b1);
        emu.wr(`BCPC_OFF_BCNT2, 32'h2);
        multistep_i <= 1'b1;
        step(4'h2);
        multistep_i <= 1'b0;
        step(4'h2);
        see("window", 1'b1);
        ce_i <= 1'b0;
        step(4'h2);
        ce_i <= 1'b1;
        see("window", 1'b1);
        step(4'h2);
        see("window", 1'b0);
        // normal mode: slot retire does not advance the halt
        emu.arm(2'h0);
        step(4'h4);
        see("window", 1'b1);
        step(4'h1);
        delay_slot_i <= 1'b1;
        step(4'h8);
        delay_slot_i <= 1'b0;
        step(4'h8);
        // A counted slot retire would have raised the halt by now
        @(posedge clk_sys_i);
        see("halt", 1'b0);
        step(4'h8);
        // Halt lands one cycle after the slip count fills
        @(posedge clk_sys_i);
        see("halt", 1'b1);
        see("window", 1'b0);
        emu.rd(`BCPC_OFF_STAT, d);
        chk("stat", 32'h6, d & 32'h7);
        close_out();
    end
endmodule // tb
